// File: src/tsisp_pkg.sv
/*
  Constants, types and bus codes for the temperature sensor two-wire slave port.
  Assumes the measurement core and limit comparators live beside it on clk_sys.
*/
// Function
// [RL1] Slave only, fast and high-speed bit rates.
// [RL2] Every byte shifted most significant bit first.
// [RL3] Master alone makes clock, START and STOP.
// [RL4] Matching address acknowledged on ninth clock.
// [RL5] Data change while clock high is control.
// [RL6] Seven address bits then direction, high reads.
// [RL7] Binary pins append to fixed four-bit prefix.
// [RL8] Ternary pins map through fixed lookup table.
// [RL9] Address pins latched at reset, START, request.
// [RL10] First write byte becomes the register pointer.
// [RL11] Reads use last written pointer, kept afterwards.
// [RL12] Pointer-only write then repeated START read.
// [RL13] Acknowledge pointer and data, write pointed register.
// [RL14] START or STOP abandons a write cleanly.
// [RL15] Read sends high byte then low byte.
// [RL16] Master ends read by not acknowledging.
// [RL17] Alert active: answer alert address with address.
// [RL18] Alert byte low bit flags high limit cause.
// [RL19] Arbitrate alert reply; only winner clears alert.
// [RL20] General call with write bit acknowledged.
// [RL21] Latch command re-samples pins, keeps registers.
// [RL22] Reset command re-samples pins, restores registers.
// [RL23] Pointer low two bits select the register.
// [RL24] Master code not acknowledged; high speed until STOP.
// [RL25] Interrupt mode: temperature read clears alert.
// [RL26] Foreign addresses left unacknowledged, line released.
package tsisp_pkg;
  typedef logic [7:0] tsisp_byte_t;
  typedef logic [11:0] tsisp_word_t;
  typedef logic [6:0] tsisp_addr_t;
  typedef logic [1:0] tsisp_pin_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_GCALL, ST_READ, ST_MACK, ST_SKIP
  } tsisp_state_e;

  localparam int FAST_RATE_KHZ = 400;
  localparam int HS_RATE_KHZ = 2000;
  localparam int LINK_CLK_NS = 32;
  localparam int HS_BIT_NS = 1000000 / HS_RATE_KHZ;
  localparam int LINK_SAMPLES_PER_BIT = HS_BIT_NS / LINK_CLK_NS;

  localparam logic [3:0] BIN_PREFIX = 4'h9;
  localparam tsisp_addr_t GC_ADDR = 7'h00;
  localparam tsisp_byte_t ARA_BYTE = 8'h19;
  localparam tsisp_byte_t GC_LATCH = 8'h04;
  localparam tsisp_byte_t GC_RESET = 8'h06;
  localparam logic [4:0] HS_PREFIX = 5'h01;

  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_TLOW = 2'h2;
  localparam logic [1:0] PTR_THIGH = 2'h3;
  localparam logic [1:0] PTR_RESET = 2'h0;
  localparam int CFG_TM_BIT = 1;
  localparam tsisp_byte_t CFG_RESET = 8'h00;
  localparam tsisp_word_t TLOW_RESET = 12'h000;
  localparam tsisp_word_t THIGH_RESET = 12'h000;
  localparam tsisp_word_t TEMP_RESET = 12'h000;

  localparam tsisp_pin_t PIN_LOW = 2'h0;
  localparam tsisp_pin_t PIN_HIGH = 2'h1;
  localparam tsisp_pin_t PIN_FLOAT = 2'h2;
endpackage

// File: src/tsisp_top.sv
/*
  Two-wire slave port: bus engine and register file on clk_link, alert logic on clk_sys.
  Assumes scl_in and sda_in are the resolved open-drain line levels and that the
  link sampling clock is several times faster than the bus bit rate.
*/
`timescale 1ns/1ps
module tsisp_top #(
  parameter bit TERNARY_PINS = 1'b1
) (
  input logic clk_sys,
  input logic nrst,
  input logic clk_link,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input tsisp_pkg::tsisp_pin_t addr_pin_zero,
  input tsisp_pkg::tsisp_pin_t addr_pin_one,
  input tsisp_pkg::tsisp_pin_t addr_pin_two,
  input tsisp_pkg::tsisp_word_t temp_result,
  input logic temp_valid,
  input logic over_high,
  input logic under_low,
  output tsisp_pkg::tsisp_byte_t config_out,
  output tsisp_pkg::tsisp_word_t tlow_out,
  output tsisp_pkg::tsisp_word_t thigh_out,
  output logic alert_latching_select,
  output logic alert_out,
  output logic high_speed_transfer
);
  import tsisp_pkg::*;

  function automatic tsisp_pin_t pin_norm(input tsisp_pin_t p);
    pin_norm = (p[1] && TERNARY_PINS) ? PIN_FLOAT : {1'b0, p[0]};
  endfunction

  // The ternary table is irregular, so it is spelled out rather than computed.
  function automatic tsisp_addr_t decode_addr(input tsisp_pin_t a2, input tsisp_pin_t a1, input tsisp_pin_t a0);
    tsisp_addr_t r;
    r = {BIN_PREFIX, a2[0], a1[0], a0[0]};
    case ({pin_norm(a2), pin_norm(a1), pin_norm(a0)})
      6'h20: r = 7'h70;
      6'h22: r = 7'h71;
      6'h21: r = 7'h72;
      6'h24: r = 7'h73;
      6'h26: r = 7'h74;
      6'h25: r = 7'h75;
      6'h28: r = 7'h76;
      6'h29: r = 7'h77;
      6'h08: r = 7'h28;
      6'h09: r = 7'h29;
      6'h18: r = 7'h2a;
      6'h19: r = 7'h2b;
      6'h02: r = 7'h2c;
      6'h06: r = 7'h2d;
      6'h12: r = 7'h2e;
      6'h16: r = 7'h2f;
      6'h0a: r = 7'h35;
      6'h1a: r = 7'h36;
      6'h2a: r = 7'h37;
      default: r = {BIN_PREFIX, a2[0], a1[0], a0[0]};
    endcase
    return r;
  endfunction

  function automatic tsisp_byte_t left_byte(input tsisp_word_t w, input logic hi);
    left_byte = hi ? w[11:4] : {w[3:0], 4'h0};
  endfunction

  // Link domain: reset and input synchronisers.
  logic lrst_meta_reg, lrst_n_reg;
  logic scl_meta_reg, scl_s_reg, scl_d_reg, sda_meta_reg, sda_s_reg, sda_d_reg;
  logic [5:0] pin_meta_reg, pin_s_reg;
  logic alert_meta_reg, alert_s_reg, cause_meta_reg, cause_s_reg;
  logic ttog_meta_reg, ttog_s_reg, ttog_d_reg;

  always_ff @(posedge clk_link) begin
    lrst_meta_reg <= nrst;
    lrst_n_reg <= lrst_meta_reg;
    scl_meta_reg <= scl_in;
    scl_s_reg <= scl_meta_reg;
    scl_d_reg <= scl_s_reg;
    sda_meta_reg <= sda_in;
    sda_s_reg <= sda_meta_reg;
    sda_d_reg <= sda_s_reg;
    pin_meta_reg <= {addr_pin_two, addr_pin_one, addr_pin_zero};
    pin_s_reg <= pin_meta_reg;
  end

  logic alert_reg, cause_reg, treq_reg;
  tsisp_word_t temp_hold_reg;

  always_ff @(posedge clk_link) begin
    alert_meta_reg <= alert_reg;
    alert_s_reg <= alert_meta_reg;
    cause_meta_reg <= cause_reg;
    cause_s_reg <= cause_meta_reg;
    ttog_meta_reg <= treq_reg;
    ttog_s_reg <= ttog_meta_reg;
    ttog_d_reg <= ttog_s_reg;
  end

  // Bus conditions seen on the synchronised lines.
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_reg && !scl_d_reg;
  assign scl_fall = !scl_s_reg && scl_d_reg;
  assign start_c = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg; // [RL5]
  assign stop_c = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg; // [RL5]

  tsisp_state_e state_reg, after_reg;
  logic [3:0] bitcnt_reg;
  tsisp_byte_t rx_reg, tx_reg;
  logic [1:0] idx_reg, ptr_reg;
  logic sda_oe_reg, hs_reg, ara_reg, hi_next_reg, acked_reg;
  tsisp_addr_t my_addr_reg;
  logic addr_init_reg;
  tsisp_byte_t cfg_l_reg;
  tsisp_word_t tlow_l_reg, thigh_l_reg, temp_l_reg;
  logic wr_tog_reg, rdclr_tog_reg, won_tog_reg, tack_tog_reg;

  logic byte_end, addr_done, wr_done, gc_done, gc_latch, gc_reset;
  logic addr_match, gc_match, ara_match, hs_code;
  tsisp_byte_t next_byte, reg_word_byte;
  tsisp_word_t sel_word;

  assign byte_end = scl_fall && bitcnt_reg == 4'h8;
  assign addr_done = byte_end && state_reg == ST_ADDR;
  assign wr_done = byte_end && state_reg == ST_WRITE;
  assign gc_done = byte_end && state_reg == ST_GCALL;
  assign gc_latch = gc_done && (rx_reg == GC_LATCH || rx_reg == GC_RESET); // [RL21]
  assign gc_reset = gc_done && rx_reg == GC_RESET; // [RL22]
  assign hs_code = rx_reg[7:3] == HS_PREFIX;
  assign addr_match = rx_reg[7:1] == my_addr_reg; // [RL6]
  assign gc_match = rx_reg == {GC_ADDR, 1'b0}; // [RL20]
  assign ara_match = rx_reg == ARA_BYTE && alert_s_reg; // [RL17]

  // Register selected by the two pointer bits.
  always_comb begin
    case (ptr_reg) // [RL23]
      PTR_TEMP: sel_word = temp_l_reg;
      PTR_TLOW: sel_word = tlow_l_reg;
      PTR_THIGH: sel_word = thigh_l_reg;
      default: sel_word = {cfg_l_reg, 4'h0};
    endcase
  end
  assign reg_word_byte = left_byte(sel_word, hi_next_reg);
  assign next_byte = (ptr_reg == PTR_CFG) ? cfg_l_reg : reg_word_byte; // [RL15]

  // Protocol engine: the line only changes on a falling clock seen here, or is released at START or STOP.
  always_ff @(posedge clk_link) begin
    if (!lrst_n_reg) begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      idx_reg <= 2'h0;
      sda_oe_reg <= 1'b0;
      ara_reg <= 1'b0;
      hi_next_reg <= 1'b1;
      acked_reg <= 1'b0;
    end else if (stop_c || start_c) begin
      state_reg <= start_c ? ST_ADDR : ST_IDLE; // [RL14]
      bitcnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      ara_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WRITE, ST_GCALL: begin
          if (scl_rise) begin
            rx_reg <= {rx_reg[6:0], sda_s_reg}; // [RL2]
            bitcnt_reg <= bitcnt_reg + 4'h1;
          end else if (byte_end) begin
            bitcnt_reg <= 4'h0;
            state_reg <= ST_ACK;
            sda_oe_reg <= 1'b1;
            if (state_reg == ST_WRITE) begin
              after_reg <= ST_WRITE; // [RL13]
              idx_reg <= (idx_reg == 2'h3) ? idx_reg : idx_reg + 2'h1;
            end else if (state_reg == ST_GCALL) begin
              after_reg <= ST_SKIP;
              sda_oe_reg <= gc_latch;
              state_reg <= gc_latch ? ST_ACK : ST_SKIP;
            end else if (hs_code) begin
              sda_oe_reg <= 1'b0; // [RL24]
              state_reg <= ST_SKIP;
            end else if (addr_match) begin
              after_reg <= rx_reg[0] ? ST_READ : ST_WRITE; // [RL4]
              idx_reg <= 2'h0;
              hi_next_reg <= 1'b0;
              tx_reg <= (ptr_reg == PTR_CFG) ? cfg_l_reg : left_byte(sel_word, 1'b1); // [RL11]
            end else if (gc_match) begin
              after_reg <= ST_GCALL;
            end else if (ara_match) begin
              after_reg <= ST_READ;
              ara_reg <= 1'b1;
              tx_reg <= {my_addr_reg, cause_s_reg}; // [RL18]
            end else begin
              sda_oe_reg <= 1'b0; // [RL26]
              state_reg <= ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_reg <= after_reg;
            if (after_reg == ST_READ) begin
              sda_oe_reg <= !tx_reg[7]; // [RL15]
              tx_reg <= {tx_reg[6:0], 1'b0};
              bitcnt_reg <= 4'h1;
            end else begin
              sda_oe_reg <= 1'b0;
              bitcnt_reg <= 4'h0;
            end
          end
        end
        ST_READ: begin
          if (scl_rise && ara_reg && !sda_oe_reg && !sda_s_reg) begin
            state_reg <= ST_SKIP; // [RL19]
          end else if (byte_end) begin
            sda_oe_reg <= 1'b0;
            bitcnt_reg <= 4'h0;
            state_reg <= ST_MACK;
          end else if (scl_fall) begin
            sda_oe_reg <= !tx_reg[7]; // [RL2]
            tx_reg <= {tx_reg[6:0], 1'b0};
            bitcnt_reg <= bitcnt_reg + 4'h1;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            acked_reg <= !sda_s_reg;
          end else if (scl_fall) begin
            if (acked_reg && !ara_reg) begin
              state_reg <= ST_READ; // [RL16]
              sda_oe_reg <= !next_byte[7];
              tx_reg <= {next_byte[6:0], 1'b0};
              bitcnt_reg <= 4'h1;
              hi_next_reg <= !hi_next_reg;
            end else begin
              state_reg <= ST_SKIP;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // High-speed filtering flag, held from the master code until STOP.
  always_ff @(posedge clk_link) begin
    if (!lrst_n_reg || stop_c) begin
      hs_reg <= 1'b0;
    end else if (addr_done && hs_code) begin
      hs_reg <= 1'b1; // [RL24]
    end
  end

  // Address pins are caught once after reset, then at each START or latch command.
  always_ff @(posedge clk_link) begin
    if (!lrst_n_reg) begin
      addr_init_reg <= 1'b0;
      my_addr_reg <= {BIN_PREFIX, 3'h0};
    end else if (!addr_init_reg || start_c || gc_latch) begin
      addr_init_reg <= 1'b1;
      my_addr_reg <= decode_addr(pin_s_reg[5:4], pin_s_reg[3:2], pin_s_reg[1:0]); // [RL7] [RL8] [RL9]
    end
  end

  // Bus-side register file; data bytes land only after the pointer byte.
  always_ff @(posedge clk_link) begin
    if (!lrst_n_reg || gc_reset) begin
      ptr_reg <= PTR_RESET; // [RL22]
      cfg_l_reg <= CFG_RESET;
      tlow_l_reg <= TLOW_RESET;
      thigh_l_reg <= THIGH_RESET;
    end else if (wr_done) begin
      if (idx_reg == 2'h0) begin
        ptr_reg <= rx_reg[1:0]; // [RL10] [RL12]
      end else if (idx_reg == 2'h1) begin
        if (ptr_reg == PTR_CFG) cfg_l_reg <= rx_reg; // [RL13]
        if (ptr_reg == PTR_TLOW) tlow_l_reg[11:4] <= rx_reg;
        if (ptr_reg == PTR_THIGH) thigh_l_reg[11:4] <= rx_reg;
      end else if (idx_reg == 2'h2) begin
        if (ptr_reg == PTR_TLOW) tlow_l_reg[3:0] <= rx_reg[7:4];
        if (ptr_reg == PTR_THIGH) thigh_l_reg[3:0] <= rx_reg[7:4];
      end
    end
  end

  // Temperature arrives by toggle handshake; the hold word is frozen until acknowledged.
  always_ff @(posedge clk_link) begin
    if (!lrst_n_reg) begin
      temp_l_reg <= TEMP_RESET;
      tack_tog_reg <= 1'b0;
    end else if (ttog_s_reg != ttog_d_reg) begin
      temp_l_reg <= temp_hold_reg;
      tack_tog_reg <= ttog_s_reg;
    end
  end

  // Events toward clk_sys travel as toggles.
  always_ff @(posedge clk_link) begin
    if (!lrst_n_reg) begin
      wr_tog_reg <= 1'b0;
      rdclr_tog_reg <= 1'b0;
      won_tog_reg <= 1'b0;
    end else begin
      if ((wr_done && idx_reg != 2'h0) || gc_reset) wr_tog_reg <= !wr_tog_reg;
      if (addr_done && addr_match && rx_reg[0] && ptr_reg == PTR_TEMP) rdclr_tog_reg <= !rdclr_tog_reg; // [RL25]
      if (byte_end && state_reg == ST_READ && ara_reg) won_tog_reg <= !won_tog_reg; // [RL19]
    end
  end

  // Open drain: the pad only ever pulls low.
  assign sda_out = 1'b0; // [RL1]
  assign sda_oe = sda_oe_reg;

  // System domain.
  logic [2:0] wr_sync_reg, rdclr_sync_reg, won_sync_reg;
  logic tack_meta_reg, tack_s_reg, hs_meta_reg, hs_s_reg, over_d_reg, under_d_reg;
  logic wr_ev, rdclr_ev, won_ev, tm, set_hi, set_lo, clr_alert;

  always_ff @(posedge clk_sys) begin
    wr_sync_reg <= {wr_sync_reg[1:0], wr_tog_reg};
    rdclr_sync_reg <= {rdclr_sync_reg[1:0], rdclr_tog_reg};
    won_sync_reg <= {won_sync_reg[1:0], won_tog_reg};
    tack_meta_reg <= tack_tog_reg;
    tack_s_reg <= tack_meta_reg;
    hs_meta_reg <= hs_reg;
    hs_s_reg <= hs_meta_reg;
  end
  assign wr_ev = wr_sync_reg[2] != wr_sync_reg[1];
  assign rdclr_ev = rdclr_sync_reg[2] != rdclr_sync_reg[1];
  assign won_ev = won_sync_reg[2] != won_sync_reg[1];

  // Words cross as-is: bytes are microseconds apart, far longer than the sync delay.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      config_out <= CFG_RESET;
      tlow_out <= TLOW_RESET;
      thigh_out <= THIGH_RESET;
      high_speed_transfer <= 1'b0;
    end else begin
      if (wr_ev) begin
        config_out <= cfg_l_reg;
        tlow_out <= tlow_l_reg;
        thigh_out <= thigh_l_reg;
      end
      high_speed_transfer <= hs_s_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      treq_reg <= 1'b0;
      temp_hold_reg <= TEMP_RESET;
    end else if (temp_valid && treq_reg == tack_s_reg) begin
      temp_hold_reg <= temp_result;
      treq_reg <= !treq_reg;
    end
  end

  assign tm = config_out[CFG_TM_BIT];
  assign alert_latching_select = tm;
  assign set_hi = tm ? (over_high && !over_d_reg) : over_high;
  assign set_lo = tm && under_low && !under_d_reg;
  assign clr_alert = won_ev || (tm ? rdclr_ev : under_low);

  // A high limit crossing, or in interrupt mode a low one, wins over a clear arriving in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      alert_reg <= 1'b0;
      cause_reg <= 1'b0;
      over_d_reg <= 1'b0;
      under_d_reg <= 1'b0;
    end else begin
      over_d_reg <= over_high;
      under_d_reg <= under_low;
      if (set_hi) begin
        alert_reg <= 1'b1; // [RL18]
        cause_reg <= 1'b1;
      end else if (set_lo) begin
        alert_reg <= 1'b1;
        cause_reg <= 1'b0;
      end else if (clr_alert) begin
        alert_reg <= 1'b0; // [RL25]
      end
    end
  end
  assign alert_out = alert_reg;

  property p_ack_match;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    addr_done && !start_c && !stop_c && addr_match && !hs_code |=> sda_oe_reg && state_reg == ST_ACK;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("Own address not acknowledged."); // [RL4]

  property p_foreign;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    addr_done && !start_c && !stop_c && !addr_match && !gc_match && !ara_match |=> !sda_oe_reg && state_reg == ST_SKIP;
  endproperty
  a_foreign: assert property (p_foreign) else $error("Foreign address acknowledged."); // [RL26]

  property p_hs_code;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    addr_done && !start_c && !stop_c && hs_code |=> hs_reg && !sda_oe_reg;
  endproperty
  a_hs_code: assert property (p_hs_code) else $error("Master code handled wrongly."); // [RL24]

  property p_hs_stop;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    stop_c |=> !hs_reg;
  endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("High speed kept after STOP."); // [RL24]

  property p_pointer;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    wr_done && !start_c && !stop_c && !gc_reset && idx_reg == 2'h0 |=> ptr_reg == $past(rx_reg[1:0]);
  endproperty
  a_pointer: assert property (p_pointer) else $error("Pointer byte not stored."); // [RL10]

  property p_msb_first;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    state_reg == ST_READ && scl_fall && bitcnt_reg != 4'h8 && !start_c && !stop_c
      |=> sda_oe_reg == !$past(tx_reg[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("Transmit bit order wrong."); // [RL2]

  property p_gc_reset;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    gc_reset |=> cfg_l_reg == CFG_RESET && ptr_reg == PTR_RESET && tlow_l_reg == TLOW_RESET;
  endproperty
  a_gc_reset: assert property (p_gc_reset) else $error("Reset command left registers."); // [RL22]

  property p_arb_lost;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    state_reg == ST_READ && ara_reg && scl_rise && !sda_oe_reg && !sda_s_reg && !start_c && !stop_c
      |=> state_reg == ST_SKIP ##1 !sda_oe_reg;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("Lost arbitration kept driving."); // [RL19]

  property p_sda_scl_low;
    @(posedge clk_link) disable iff (!lrst_n_reg)
    $changed(sda_oe_reg) && !$past(start_c) && !$past(stop_c) |-> !$past(scl_s_reg);
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("Data changed while clock high."); // [RL5]

  property p_alert_high;
    @(posedge clk_sys) disable iff (!nrst)
    tm && over_high && !over_d_reg |=> alert_reg && cause_reg;
  endproperty
  a_alert_high: assert property (p_alert_high) else $error("High crossing not flagged."); // [RL18]

  property p_alert_clear;
    @(posedge clk_sys) disable iff (!nrst)
    tm && rdclr_ev && !set_hi && !set_lo |=> !alert_reg;
  endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("Temperature read kept alert."); // [RL25]

  c_write: cover property (@(posedge clk_link) disable iff (!lrst_n_reg) wr_done && idx_reg == 2'h2);
  c_read: cover property (@(posedge clk_link) disable iff (!lrst_n_reg) state_reg == ST_MACK && !ara_reg && acked_reg);
  c_ara_won: cover property (@(posedge clk_sys) disable iff (!nrst) won_ev);
  c_gc_reset: cover property (@(posedge clk_link) disable iff (!lrst_n_reg) gc_reset);
endmodule

// File: tb/tsisp_master.sv
/*
  Behavioural two-wire bus master that stands on the far side of the slave port.
  Assumes the bench resolves SDA from both pull-down enables with a pull-up.
*/
`timescale 1ns/1ps
module tsisp_master (
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  localparam int HALF = 250;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // SCL stands high between frames; only this side makes START and STOP.
  task automatic start();
    #50 sda_low = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask
  task automatic stop();
    #50 sda_low = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
  // Data moves 50 ns after SCL falls, so the slave never sees a false condition.
  task automatic bit_io(input logic b, output logic r);
    #50 sda_low = ~b;
    #HALF scl = 1'b1;
    #HALF r = sda_line;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // The last byte of a read is answered with a not-acknowledge.
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, r);
  endtask
endmodule

// File: tb/tsisp_top_tb_top.sv
/*
  Self-checking bench for the two-wire slave port with ternary address pins.
  Assumes a pull-up on SDA and the bus master model in tsisp_master.
*/
`timescale 1ns/1ps
module tsisp_top_tb_top;
  import tsisp_pkg::*;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic nrst = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, sda_line, als, alert_out, hs, ack;
  logic temp_valid = 1'b0;
  logic over_high = 1'b0;
  logic under_low = 1'b0;
  tsisp_pin_t p0 = PIN_HIGH;
  tsisp_pin_t p1 = PIN_LOW;
  tsisp_pin_t p2 = PIN_FLOAT;
  tsisp_word_t temp = 12'h000;
  tsisp_word_t tlow_out, thigh_out;
  tsisp_byte_t config_out, hi, lo;
  tsisp_addr_t adr = 7'h72;
  int fails = 0;
  int n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  always #16 clk_link = ~clk_link;
  assign sda_line = ~(sda_low | sda_oe);
  tsisp_master bus_u (.sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  tsisp_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin_zero(p0), .addr_pin_one(p1), .addr_pin_two(p2),
    .temp_result(temp), .temp_valid(temp_valid), .over_high(over_high), .under_low(under_low),
    .config_out(config_out), .tlow_out(tlow_out), .thigh_out(thigh_out), .alert_latching_select(als),
    .alert_out(alert_out), .high_speed_transfer(hs));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // A wait that runs out counts as a mismatch and ends the run.
  task automatic wait_bit(input logic sel, input logic v);
    for (int i = 0; i < 40 && (sel ? hs : alert_out) !== v; i++) begin
      @(posedge clk_sys);
    end
    chk(sel ? hs : alert_out, v);
    if ((sel ? hs : alert_out) !== v) begin
      end_of_test();
    end
  endtask
  // A count below zero leaves the bus open for a repeated START.
  task automatic wr(input tsisp_byte_t p, input tsisp_byte_t b1, input tsisp_byte_t b2, input int n);
    bus_u.start();
    bus_u.wbyte({adr, 1'b0}, ack);
    chk(ack, 1'b1);
    bus_u.wbyte(p, ack);
    chk(ack, 1'b1);
    if (n > 0) begin
      bus_u.wbyte(b1, ack);
      chk(ack, 1'b1);
    end
    if (n > 1) begin
      bus_u.wbyte(b2, ack);
      chk(ack, 1'b1);
    end
    if (n >= 0) begin
      bus_u.stop();
      repeat (10) @(posedge clk_sys);
    end
  endtask
  task automatic rd();
    bus_u.start();
    bus_u.wbyte({adr, 1'b1}, ack);
    chk(ack, 1'b1);
    bus_u.rbyte(1'b1, hi);
    bus_u.rbyte(1'b0, lo);
    bus_u.stop();
  endtask
  task automatic t_refuse();
    chk(config_out, CFG_RESET);
    chk(tlow_out | thigh_out, TLOW_RESET);
    chk(sda_out, 1'b0);
    bus_u.start();
    bus_u.wbyte(8'h08, ack);
    chk(ack, 1'b0);
    wait_bit(1'b1, 1'b1);
    bus_u.start();
    bus_u.wbyte(8'h90, ack);
    chk(ack, 1'b0);
    bus_u.start();
    bus_u.wbyte(ARA_BYTE, ack);
    chk(ack, 1'b0);
    bus_u.stop();
    wait_bit(1'b1, 1'b0);
    $display("test refuse done");
  endtask
  task automatic t_regs();
    wr({6'h00, PTR_TLOW}, 8'hAB, 8'hC0, 2);
    chk(tlow_out, 12'hABC);
    wr({6'h00, PTR_THIGH}, 8'h12, 8'h34, 2);
    chk(thigh_out, 12'h123);
    wr({6'h00, PTR_TLOW}, 8'h00, 8'h00, -1);
    rd();
    chk({hi[3:0], lo}, 12'hBC0);
    chk(hi, 8'hAB);
    rd();
    chk({hi, lo[7:4]}, 12'hABC);
    $display("test regs done");
  endtask
  task automatic t_temp();
    @(negedge clk_sys);
    temp = 12'h5A7;
    temp_valid = 1'b1;
    @(negedge clk_sys);
    temp_valid = 1'b0;
    wr({6'h00, PTR_TEMP}, 8'hFF, 8'hFF, 2);
    rd();
    chk({hi, lo[7:4]}, 12'h5A7);
    $display("test temp done");
  endtask
  task automatic t_gcall();
    @(negedge clk_sys);
    p2 = PIN_LOW;
    p1 = PIN_HIGH;
    adr = GC_ADDR;
    wr(GC_LATCH, 8'h00, 8'h00, 0);
    adr = 7'h4B;
    chk(thigh_out, 12'h123);
    rd();
    chk({hi, lo[7:4]}, 12'h5A7);
    adr = GC_ADDR;
    wr(GC_RESET, 8'h00, 8'h00, 0);
    adr = 7'h4B;
    chk(tlow_out | thigh_out, TLOW_RESET);
    $display("test gcall done");
  endtask
  task automatic t_alert();
    wr({6'h00, PTR_CFG}, 8'h02, 8'h00, 1);
    chk(als, 1'b1);
    @(negedge clk_sys);
    over_high = 1'b1;
    wait_bit(1'b0, 1'b1);
    bus_u.start();
    bus_u.wbyte(ARA_BYTE, ack);
    chk(ack, 1'b1);
    bus_u.rbyte(1'b0, hi);
    chk(hi, {adr, 1'b1});
    bus_u.stop();
    wait_bit(1'b0, 1'b0);
    @(negedge clk_sys);
    over_high = 1'b0;
    under_low = 1'b1;
    wait_bit(1'b0, 1'b1);
    // A rival holding SDA low through the reply must win at the first bit, where 7'h4B sends a one, so the alert stays.
    bus_u.start();
    bus_u.wbyte(ARA_BYTE, ack);
    chk(ack, 1'b1);
    bus_u.wbyte(8'h00, ack);
    chk(ack, 1'b0);
    bus_u.stop();
    repeat (10) @(posedge clk_sys);
    chk(alert_out, 1'b1);
    wr({6'h00, PTR_TEMP}, 8'h00, 8'h00, 0);
    rd();
    wait_bit(1'b0, 1'b0);
    $display("test alert done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    repeat (10) @(posedge clk_sys);
    t_refuse();
    t_regs();
    t_temp();
    t_gcall();
    t_alert();
    end_of_test();
  end
endmodule
